// ### hdl/phy_opmode_config_regs.v
/*
  phy parameter and operation mode register bank. software sees every
  field read-only through the config read port; defaults are replaced by
  a load port driven by the smbus/i2c slave or the eeprom autoloader.
  assumes one synchronous clock, reads answered one cycle later, and that
  the load master holds off while reset is asserted.
*/
`timescale 1ns/1ps
`include "phy_opmode_consts.vh"
module phy_opmode_config_regs #(
  parameter UPSTREAM = 1 // this instance is the upstream port's copy
) (
  // clock, reset, enable
  input wire sys_clk_in,
  input wire reset_in,
  input wire clk_en_in,
  // configuration space access
  input wire cfg_rd_in,
  input wire cfg_wr_in,
  input wire [7:0] cfg_addr_in,
  input wire [31:0] cfg_wdata_in,
  output reg [31:0] cfg_rdata_out,
  output reg cfg_rvalid_out,
  // default loads from smbus/i2c or eeprom
  input wire load_wr_in,
  input wire [2:0] load_sel_in,
  input wire [16:0] load_data_in,
  // upstream copy of the delta setting
  input wire [16:0] upstream_delta_in,
  // straps
  input wire eeprom_load_bypass_in,
  input wire quiescent_current_test_in,
  input wire fast_mode_in,
  input wire debug_mode_in,
  input wire phy_mode_in,
  input wire [1:0] package_select_in,
  input wire [1:0] placement_select_in,
  input wire refclk_buffer_powerdown_strap_in,
  // controls to the rest of the switch
  output reg phy_retrain_enable_out,
  output reg [6:0] reference_clock_output_pairs_en_out,
  output reg [6:0] phy_lane_mode_out,
  output reg [15:0] phy_tx_margin_out
);
  reg [6:0] lane_mode_q; // per-lane mode
  reg [16:0] delta_q; // global delta, local copy
  reg [15:0] margin_q; // tx margin
  reg [8:0] mode_q; // strap-derived operation mode
  reg clk_pd_q; // global clock buffer power-down
  reg [6:0] clk_en_q; // per-pair enables
  reg [3:0] l1pm_q; // l1 pm option
  reg [7:0] phy_control_byte_q; // phy control byte
  reg mode_loaded_q; // mode captured from straps once
  reg [31:0] rdata_d;
  wire strap_load;
  wire strap_level;
  wire [16:0] delta_eff;

  strap_capture u_strap (
    .sys_clk_in(sys_clk_in),
    .reset_in(reset_in),
    .clk_en_in(clk_en_in),
    .strap_in(refclk_buffer_powerdown_strap_in),
    .load_out(strap_load),
    .level_out(strap_level)
  );

  // downstream ports mirror the upstream value instead of their own
  assign delta_eff = (UPSTREAM != 0) ? delta_q : upstream_delta_in;

  // field storage: reset defaults, then strap and load-port overrides
  always @(posedge sys_clk_in) begin
    if (reset_in) begin
      lane_mode_q <= `LANE_MODE_RST;
      delta_q <= `DELTA_RST;
      margin_q <= `MARGIN_RST;
      mode_q <= `MODE_RST;
      clk_pd_q <= 1'b0;
      clk_en_q <= `CLKEN_RST;
      l1pm_q <= `L1PM_RST;
      phy_control_byte_q <= `PHY_CONTROL_RST;
      mode_loaded_q <= 1'b0;
    end else if (clk_en_in) begin
      // strap values land first; a same-cycle load still overrides below
      if (strap_load) begin
        clk_pd_q <= strap_level;
      end
      if (!mode_loaded_q) begin
        mode_q <= {placement_select_in, package_select_in, phy_mode_in, debug_mode_in,
                   fast_mode_in, quiescent_current_test_in, eeprom_load_bypass_in};
        mode_loaded_q <= 1'b1;
      end
      // software writes are dropped: all fields read-only to it
      if (load_wr_in) begin
        case (load_sel_in)
          `SEL_LANE_MODE: lane_mode_q <= load_data_in[6:0];
          `SEL_DELTA: begin
            if (UPSTREAM != 0) begin
              delta_q <= load_data_in;
            end
          end
          `SEL_MARGIN: margin_q <= load_data_in[15:0];
          `SEL_MODE: mode_q <= load_data_in[8:0];
          `SEL_CLKCTL: begin
            clk_en_q <= load_data_in[6:0];
            clk_pd_q <= load_data_in[7];
          end
          `SEL_L1PM: l1pm_q <= load_data_in[3:0];
          `SEL_PHY_CONTROL: phy_control_byte_q <= load_data_in[7:0];
          default: ; // unknown selects ignored
        endcase
      end
    end
  end

  // read mux; reserved bits left at zero
  always @* begin
    rdata_d = 32'h00000000;
    case (cfg_addr_in)
      `OFS_PHY_LANE_DELTA: begin
        rdata_d[`LANE_MODE_HI:`LANE_MODE_LO] = lane_mode_q;
        rdata_d[`DELTA_HI:`DELTA_LO] = delta_eff;
      end
      `OFS_PHY_TX_MARGIN: rdata_d[`MARGIN_HI:`MARGIN_LO] = margin_q;
      `OFS_OPMODE: begin
        rdata_d[`MODE_HI:`MODE_LO] = mode_q;
        rdata_d[`CLKEN_HI:`CLKEN_LO] = clk_en_q;
        rdata_d[`CLK_GLOBAL_PD] = clk_pd_q;
        rdata_d[`L1PM_HI:`L1PM_LO] = l1pm_q;
      end
      `OFS_PHY_CONTROL: rdata_d[7:0] = phy_control_byte_q;
      default: rdata_d = 32'h00000000; // unmapped reads zero
    endcase
  end

  // registered outputs; cfg_wr_in only suppresses cfg_rvalid_out and never changes a field
  always @(posedge sys_clk_in) begin
    if (reset_in) begin
      cfg_rdata_out <= 32'h00000000;
      cfg_rvalid_out <= 1'b0;
      phy_retrain_enable_out <= 1'b1;
      reference_clock_output_pairs_en_out <= 7'h00;
      phy_lane_mode_out <= `LANE_MODE_RST;
      phy_tx_margin_out <= `MARGIN_RST;
    end else if (clk_en_in) begin
      cfg_rvalid_out <= cfg_rd_in & ~cfg_wr_in;
      if (cfg_rd_in) begin
        cfg_rdata_out <= rdata_d;
      end
      phy_retrain_enable_out <= ~phy_control_byte_q[`RETRAIN_DIS_BIT];
      // global disable overrides every per-pair enable
      reference_clock_output_pairs_en_out <= clk_pd_q ? 7'h00 : clk_en_q;
      phy_lane_mode_out <= lane_mode_q;
      phy_tx_margin_out <= margin_q;
    end
  end
endmodule // phy_opmode_config_regs

// ### hdl/phy_opmode_consts.vh
/*
  constants for the phy parameter / operation mode register bank:
  offsets, field positions, reset values and strap-derived defaults.
  assumes it is included by bare name from the design files only.
*/
// Notes on behaviour
// - control bit 0 set disables error retraining
// - read-only fields accept default loads externally
// - delta field 31:15, resets one, upstream only
// - lane mode bits 6:0 reset to zero
// - mode bits report straps, reset 0x0122
// - bit 23 gates all reference clock outputs
// - bit 23 reset value comes from strap
// - bits 22:16 enable pairs, reset 0x1f
`ifndef PHY_OPMODE_CONSTS_VH
`define PHY_OPMODE_CONSTS_VH

// register offsets (byte addresses)
`define OFS_PHY_LANE_DELTA 8'h90
`define OFS_PHY_TX_MARGIN 8'h94
`define OFS_OPMODE 8'h98
`define OFS_PHY_CONTROL 8'h9c

// field positions
`define LANE_MODE_HI 6
`define LANE_MODE_LO 0
`define DELTA_HI 31
`define DELTA_LO 15
`define MARGIN_HI 15
`define MARGIN_LO 0
`define MODE_HI 8
`define MODE_LO 0
`define CLKEN_HI 22
`define CLKEN_LO 16
`define CLK_GLOBAL_PD 23
`define L1PM_HI 27
`define L1PM_LO 24
`define RETRAIN_DIS_BIT 0

// reset values
`define LANE_MODE_RST 7'h00
`define DELTA_RST 17'h00001
`define MARGIN_RST 16'h116b
`define MODE_RST 9'h122
`define CLKEN_RST 7'h1f
`define L1PM_RST 4'h0
`define PHY_CONTROL_RST 8'h00

// load port field selects
`define SEL_LANE_MODE 3'h0
`define SEL_DELTA 3'h1
`define SEL_MARGIN 3'h2
`define SEL_MODE 3'h3
`define SEL_CLKCTL 3'h4
`define SEL_L1PM 3'h5
`define SEL_PHY_CONTROL 3'h6

`endif

// ### hdl/strap_capture.v
/*
  strap capture: latches the clock-buffer power-down strap level in the
  first enabled cycle after reset release. assumes the strap is steady
  around reset and synchronous to sys_clk_in.
*/
`timescale 1ns/1ps
module strap_capture (
  // clock and reset
  input wire sys_clk_in,
  input wire reset_in,
  input wire clk_en_in,
  // strap
  input wire strap_in,
  // captured level and its one-cycle load request
  output reg load_out,
  output reg level_out
);
  reg armed_q; // high while a capture is still owed

  // reset arms and clears both outputs; the pin is sampled by the clock, never by the reset
  always @(posedge sys_clk_in) begin
    if (reset_in) begin
      armed_q <= 1'b1;
      load_out <= 1'b0;
      level_out <= 1'b0;
    end else if (clk_en_in) begin
      load_out <= armed_q; // pulse once after release
      if (armed_q) begin
        level_out <= strap_in;
      end
      armed_q <= 1'b0;
    end
  end
endmodule // strap_capture

// ### test/phy_opmode_monitor.sv
/* checker for the phy/opmode register bank ports.
   assumes one clock domain; bound to every bank instance. */
`timescale 1ns/1ps
module phy_opmode_monitor (
  input logic sys_clk_in, reset_in, clk_en_in, cfg_rd_in, cfg_wr_in, cfg_rvalid_out, load_wr_in,
  input logic [7:0] cfg_addr_in,
  input logic [31:0] cfg_rdata_out,
  input logic [2:0] load_sel_in,
  input logic [16:0] load_data_in,
  input logic phy_retrain_enable_out,
  input logic [6:0] reference_clock_output_pairs_en_out, phy_lane_mode_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);
  // a read taken at this edge; a write beside it cancels the read
  wire rd_ok = cfg_rd_in && clk_en_in && !cfg_wr_in;
  property p_rvalid; rd_ok |=> cfg_rvalid_out; endproperty
  a_rvalid: assert property (p_rvalid) else $error("read not answered");
  property p_wr_ign; cfg_wr_in && clk_en_in |=> !cfg_rvalid_out; endproperty
  a_wr_ign: assert property (p_wr_ign) else $error("write answered");
  property p_rsv90; rd_ok && cfg_addr_in == 8'h90 |=> cfg_rdata_out[14:7] == 8'h00; endproperty
  a_rsv90: assert property (p_rsv90) else $error("0x90 reserved set");
  property p_rsv94; rd_ok && cfg_addr_in == 8'h94 |=> cfg_rdata_out[31:16] == 16'h0000; endproperty
  a_rsv94: assert property (p_rsv94) else $error("0x94 reserved set");
  property p_rsv98; rd_ok && cfg_addr_in == 8'h98 |=> !cfg_rdata_out[31:28] && !cfg_rdata_out[15:9]; endproperty
  a_rsv98: assert property (p_rsv98) else $error("0x98 reserved set");
  property p_unmap; rd_ok && cfg_addr_in == 8'ha0 |=> cfg_rdata_out == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  // the pair enables lag the field by one register, as the read data does
  property p_pairs; rd_ok && cfg_addr_in == 8'h98 |=>
    reference_clock_output_pairs_en_out == (cfg_rdata_out[23] ? 7'h00 : cfg_rdata_out[22:16]); endproperty
  a_pairs: assert property (p_pairs) else $error("pair enables wrong");
  property p_retrain; load_wr_in && clk_en_in && load_sel_in == 3'h6 ##1 clk_en_in |=>
    phy_retrain_enable_out == !$past(load_data_in[0], 2); endproperty
  a_retrain: assert property (p_retrain) else $error("retrain enable wrong");
  property p_lane; load_wr_in && clk_en_in && load_sel_in == 3'h0 ##1 clk_en_in |=>
    phy_lane_mode_out == $past(load_data_in[6:0], 2); endproperty
  a_lane: assert property (p_lane) else $error("lane mode not loaded");
  c_pd: cover property (cfg_rvalid_out && cfg_rdata_out[23]);
  c_off: cover property (!phy_retrain_enable_out);
  c_unmap: cover property (rd_ok && cfg_addr_in == 8'ha0);
endmodule // phy_opmode_monitor
bind phy_opmode_config_regs phy_opmode_monitor mon_u (.*);

// ### test/tb.sv
/* bench for the phy/opmode register bank: reads and default loads.
   assumes the default upstream instance; inputs change at falling edges. */
`timescale 1ns/1ps
module tb;
  logic clk = 0, rst = 1, rd = 0, wr = 0, lw = 0, spd = 1;
  logic [7:0] ad = 0;
  logic [31:0] wd = 0;
  logic [2:0] ls = 0;
  logic [16:0] ldt = 0;
  logic [8:0] st = 9'h123; // strap levels in mode bit order
  wire [31:0] rdt;
  wire rv, ren;
  wire [6:0] pen, lane;
  wire [15:0] mar;
  int bad_count = 0, checks = 0, cyc = 0;
  phy_opmode_config_regs dut_u (.sys_clk_in(clk), .reset_in(rst), .clk_en_in(1'b1),
    .cfg_rd_in(rd), .cfg_wr_in(wr), .cfg_addr_in(ad), .cfg_wdata_in(wd), .cfg_rdata_out(rdt),
    .cfg_rvalid_out(rv), .load_wr_in(lw), .load_sel_in(ls), .load_data_in(ldt),
    .upstream_delta_in(17'h00000), .eeprom_load_bypass_in(st[0]), .quiescent_current_test_in(st[1]),
    .fast_mode_in(st[2]), .debug_mode_in(st[3]), .phy_mode_in(st[4]), .package_select_in(st[6:5]),
    .placement_select_in(st[8:7]), .refclk_buffer_powerdown_strap_in(spd),
    .phy_retrain_enable_out(ren), .reference_clock_output_pairs_en_out(pen),
    .phy_lane_mode_out(lane), .phy_tx_margin_out(mar));
  initial forever #2 clk = ~clk;
  // a hang ends the run as a mismatch
  always @(posedge clk) begin
    cyc++;
    if (cyc == 1000) begin
      bad_count++;
      end_of_test;
    end
  end
  task end_of_test;
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e, input string m);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %0t %s", $time, m);
    end
  endtask
  task rs(input logic p);
    spd = p;
    rst = 1;
    repeat (12) @(negedge clk);
    rst = 0;
    repeat (4) @(negedge clk);
  endtask
  task rr(input logic [7:0] a, input logic [31:0] e);
    @(negedge clk) {rd, ad} = {1'b1, a};
    // rvalid stands for one cycle only: look at it before it drops
    @(negedge clk) chk(rv, 1, "no answer");
    chk(rdt, e, "read data");
    rd = 0;
    @(negedge clk);
  endtask
  task ld(input logic [2:0] s, input logic [16:0] d);
    @(negedge clk) {lw, ls, ldt} = {1'b1, s, d};
    @(negedge clk) lw = 0;
    @(negedge clk);
  endtask
  initial begin
    rs(1);
    rr(8'h90, 32'h00008000);
    rr(8'h94, 32'h0000116b);
    rr(8'h98, 32'h009f0123);
    chk(pen, 0, "pairs on");
    chk(ren, 1, "retrain off");
    $display("test reset done");
    ld(4, 17'h00005);
    rr(8'h98, 32'h00050123);
    chk(pen, 7'h05, "pairs");
    ld(4, 17'h00085);
    chk(pen, 0, "global off");
    ld(6, 17'h00001);
    chk(ren, 0, "retrain on");
    rr(8'h9c, 32'h00000001);
    ld(6, 17'h00000);
    chk(ren, 1, "retrain off");
    $display("test loads done");
    ld(1, 17'h1abcd);
    ld(0, 17'h0007f);
    ld(2, 17'h0beef);
    ld(5, 17'h0000a);
    @(negedge clk) {wr, ad, wd} = {1'b1, 8'h94, 32'hffffffff};
    @(negedge clk) wr = 0;
    rr(8'h90, {17'h1abcd, 8'h00, 7'h7f});
    rr(8'h94, 32'h0000beef);
    chk(mar, 16'hbeef, "margin");
    chk(lane, 7'h7f, "lane");
    rr(8'h98, 32'h0a850123);
    rr(8'ha0, 32'h00000000);
    $display("test fields done");
    rs(0);
    rr(8'h98, 32'h001f0123);
    chk(pen, 7'h1f, "pairs reset");
    $display("test strap done");
    end_of_test;
  end
endmodule // tb
